// *** verilog/clock_source_and_divider.sv ***
// Root oscillator selection, RC trim, CPU clock divider and register slave
//
// Function
// [RULE1] Machine cycle spans two CPU clock cycles
// [RULE2] Peripheral clock is CPU clock halved
// [RULE3] Root clock from one of three strapped sources
// [RULE4] RC oscillator runs at nominal 7.373 MHz
// [RULE5] Six-bit software trim retunes RC oscillator
// [RULE6] Trim loads factory value on power-on only
// [RULE7] Enabled clock output runs at half CPU clock
// [RULE8] Watchdog oscillator at 400 kHz is selectable
// [RULE9] External clock up to 18 MHz, reset pin
// [RULE10] Divider up to 510, changeable any time
// [RULE11] Wake-up waits 224 root cycles plus time
// [RULE12] Divide by twice setting, zero passes through
//
// Design decision made here: the AXI4-Lite slave port.
`include "clk_cfg.svh"

module clock_source_and_divider
#(
  parameter logic [5:0] TRIM_FACTORY = 6'h20, // Calibration value, arbitrary default
  parameter int TRIM_LSB_HZ = 40000, // RC frequency step per trim count
  parameter int WAKE_EXTRA_CYCLES = `WAKE_EXTRA_CYCLES // Wake-up time in system cycles
)
(
  input wire logic aclk, // System clock, 100 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic por_n, // Power-on reset, synchronous, active low
  input wire logic [1:0] osc_select, // Nonvolatile source choice
  input wire logic reset_pin_strap, // Nonvolatile reset pin function
  input wire logic external_clock_pin, // External clock input
  input wire logic wake_req, // Pulse: wake from power-down
  input wire logic [11:0] awaddr, // AXI write address
  input wire logic [2:0] awprot, // AXI write protection, unused
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI write strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [11:0] araddr, // AXI read address
  input wire logic [2:0] arprot, // AXI read protection, unused
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read valid
  input wire logic rready, // AXI read ready
  output logic root_osc_clock, // Root oscillator tick
  output logic rc_osc_clock, // RC oscillator tick
  output logic [5:0] rc_trim_code, // Trim code to the RC oscillator
  output logic cpu_core_clock, // CPU clock tick
  output logic periph_clock, // Peripheral clock tick
  output logic machine_cycle, // Machine cycle tick
  output logic clock_out_pin, // Clock output pin
  output logic cpu_clock_ready // Wake-up wait is over
);

  clk_pkg::top_state_t st;
  clk_pkg::top_state_t next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Register index of a byte address, or the bad index when misaligned or out of range
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0)
    begin
      idx = `BAD_INDEX;
    end
    else if (idx != `DIV_INDEX && idx != `TRIM_INDEX && idx != `STATUS_INDEX)
    begin
      idx = `BAD_INDEX;
    end
    return idx;
  endfunction

  // Phase step of a 32-bit accumulator that overflows hz times a second
  function automatic logic [31:0] nco_step(input longint hz);
    longint step;
    step = (hz <<< 32) / longint'(`SYS_CLOCK_HZ);
    return step[31:0];
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Oscillators, source select and the register slave share one record
  always_comb
  begin
    logic [32:0] rc_sum;
    logic [32:0] wdt_sum;
    longint rc_hz;
    logic [7:0] widx;
    logic [7:0] ridx;
    rc_hz = longint'(`RC_NOMINAL_HZ) // [RULE4]
      + (longint'(st.trim[5:0]) - longint'(TRIM_FACTORY)) * longint'(TRIM_LSB_HZ); // [RULE5]
    rc_sum = {1'b0, st.rc_acc} + {1'b0, nco_step(rc_hz)};
    wdt_sum = {1'b0, st.wdt_acc} + {1'b0, nco_step(longint'(`WDT_OSC_HZ))}; // [RULE8]
    widx = reg_index(st.aw_addr);
    ridx = reg_index(araddr);
    next_st = st;
    if (!aresetn || !por_n)
    begin
      next_st = '0;
      next_st.divide = `DIV_RESET;
      next_st.trim = por_n ? st.trim : {2'h0, TRIM_FACTORY}; // [RULE6]
      // Straps are fixed at programming time, so they are only taken in reset
      case (osc_select) // [RULE3]
        2'h1: next_st.src = clk_pkg::SRC_WDT;
        2'h2: next_st.src = clk_pkg::SRC_EXT;
        default: next_st.src = clk_pkg::SRC_RC;
      endcase
      next_st.rst_pin = reset_pin_strap;
    end
    else
    begin
      // Oscillators as phase accumulators; the carry is one oscillator cycle
      next_st.rc_acc = rc_sum[31:0];
      next_st.rc_tick = rc_sum[32];
      next_st.wdt_acc = wdt_sum[31:0];
      next_st.ext_q = external_clock_pin;
      next_st.ext_prev = st.ext_q;
      case (st.src) // [RULE3]
        clk_pkg::SRC_RC: next_st.root_tick = rc_sum[32];
        clk_pkg::SRC_WDT: next_st.root_tick = wdt_sum[32]; // [RULE8]
        clk_pkg::SRC_EXT: next_st.root_tick = st.ext_q && !st.ext_prev;
        default: next_st.root_tick = 1'b0;
      endcase

      // Write path: address and data may arrive in either order
      if (st.bvalid && bready)
      begin
        next_st.bvalid = 1'b0;
      end
      if (awvalid && st.awready)
      begin
        next_st.aw_have = 1'b1;
        next_st.aw_addr = awaddr;
      end
      if (wvalid && st.wready)
      begin
        next_st.w_have = 1'b1;
        next_st.w_data = wdata[7:0];
        next_st.w_lane = wstrb[0];
      end
      if (st.aw_have && st.w_have)
      begin
        next_st.aw_have = 1'b0;
        next_st.w_have = 1'b0;
        next_st.bvalid = 1'b1;
        next_st.bresp = (widx == `BAD_INDEX) ? `AXI_SLVERR : `AXI_OKAY;
        if (st.w_lane && widx == `DIV_INDEX)
        begin
          next_st.divide = st.w_data; // [RULE10]
        end
        if (st.w_lane && widx == `TRIM_INDEX)
        begin
          next_st.trim = st.w_data; // [RULE5]
        end
      end

      // Read path: one read outstanding
      if (st.rvalid && rready)
      begin
        next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready)
      begin
        next_st.rvalid = 1'b1;
        next_st.rresp = (ridx == `BAD_INDEX) ? `AXI_SLVERR : `AXI_OKAY;
        case (ridx)
          `DIV_INDEX: next_st.rdata = st.divide;
          `TRIM_INDEX: next_st.rdata = st.trim;
          `STATUS_INDEX: next_st.rdata = {4'h0, st.rst_pin, cpu_clock_ready, st.src};
          default: next_st.rdata = 8'h00;
        endcase
      end
    end
    // Ready only while there is room, so the bus cannot overrun a held word
    next_st.awready = !next_st.aw_have && !next_st.bvalid;
    next_st.wready = !next_st.w_have && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // ----------------------------------------------------------------------
  // Divider and wake-up timer
  // ----------------------------------------------------------------------
  clock_divider u_divider
  (
    .aclk(aclk),
    .aresetn(aresetn && por_n),
    .root_tick(st.root_tick),
    .run(cpu_clock_ready), // [RULE11]
    .divide_factor(st.divide), // [RULE12]
    .clk_out_en(st.trim[`TRIM_CLOCK_OUT_PIN_BIT]), // [RULE7]
    .cpu_tick(cpu_core_clock),
    .periph_tick(periph_clock),
    .machine_tick(machine_cycle),
    .clk_out(clock_out_pin)
  );

  wakeup_timer #(
    .ROOT_CYCLES(`WAKE_ROOT_CYCLES),
    .EXTRA_CYCLES(WAKE_EXTRA_CYCLES)
  ) u_wakeup
  (
    .aclk(aclk),
    .aresetn(aresetn && por_n),
    .root_tick(st.root_tick),
    .wake_req(wake_req),
    .ready(cpu_clock_ready)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Bus answers and oscillator ticks come straight from the state record
  assign awready = st.awready;
  assign wready = st.wready;
  assign arready = st.arready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = {24'h000000, st.rdata};
  assign root_osc_clock = st.root_tick;
  assign rc_osc_clock = st.rc_tick;
  assign rc_trim_code = st.trim[5:0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  trim_kept_a: assert property (@(posedge aclk) // [RULE6]
    !aresetn && por_n |=> st.trim == $past(st.trim))
    else $error("Non-power-on reset changed the trim register");
  trim_factory_a: assert property (@(posedge aclk) // [RULE6]
    !por_n |=> st.trim == {2'h0, TRIM_FACTORY})
    else $error("Power-on reset did not load the factory trim");
  source_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n) // [RULE3]
    ##1 st.src == $past(st.src))
    else $error("Root source changed outside reset");
  ext_root_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n) // [RULE3]
    st.src == clk_pkg::SRC_EXT && st.ext_q && !st.ext_prev |=> root_osc_clock)
    else $error("External clock edge gave no root tick");
  trim_write_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n) // [RULE5]
    st.aw_have && st.w_have && st.w_lane && reg_index(st.aw_addr) == `TRIM_INDEX
    |=> rc_trim_code == $past(st.w_data[5:0]) ##1 rc_trim_code == $past(st.w_data[5:0], 2))
    else $error("Trim write did not reach the RC oscillator");
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn || !por_n)
    st.aw_have && st.w_have |=> bvalid && !awready && !wready)
    else $error("Write not answered one cycle after address and data");

endmodule // clock_source_and_divider

// *** verilog/clk_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the clock block
`ifndef CLK_CFG_SVH
`define CLK_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DIV_INDEX 8'h95
`define TRIM_INDEX 8'h96
`define STATUS_INDEX 8'h97
`define BAD_INDEX 8'hff

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define DIV_RESET 8'h00
`define TRIM_VAL_WIDTH 6
`define TRIM_CLOCK_OUT_PIN_BIT 6
`define STAT_READY_BIT 2
`define STAT_RSTPIN_BIT 3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

// ----------------------------------------------------------------------
// Rates and times
// ----------------------------------------------------------------------
`define SYS_CLOCK_HZ 100000000
`define CLK_PERIOD_NS 10
`define RC_NOMINAL_HZ 7373000
`define WDT_OSC_HZ 400000
`define WAKE_ROOT_CYCLES 224
`define WAKE_EXTRA_NS 60000
`define WAKE_EXTRA_CYCLES ((`WAKE_EXTRA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** verilog/clk_pkg.sv ***
// Types shared by the clock source and divider files
package clk_pkg;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SRC_RC, SRC_WDT, SRC_EXT} osc_src_t;
  typedef enum logic [1:0] {WAKE_ROOT, WAKE_EXTRA, WAKE_RUN} wake_phase_t;

  // ----------------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] cnt;
    logic [7:0] cur_m;
    logic phase;
    logic cpu_tick;
    logic periph_tick;
    logic machine_tick;
    logic clk_out;
  } div_state_t;

  typedef struct packed {
    wake_phase_t phase;
    logic [7:0] root_cnt;
    logic [15:0] extra_cnt;
    logic ready;
  } wake_state_t;

  typedef struct packed {
    osc_src_t src;
    logic rst_pin;
    logic [31:0] rc_acc;
    logic [31:0] wdt_acc;
    logic ext_q;
    logic ext_prev;
    logic rc_tick;
    logic root_tick;
    logic [7:0] divide;
    logic [7:0] trim;
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

endpackage

// *** verilog/clock_divider.sv ***
// Divide-by-2M CPU clock enable with peripheral, machine-cycle and clock-out ticks
`include "clk_cfg.svh"

module clock_divider
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic root_tick, // One pulse per root oscillator cycle
  input wire logic run, // Wake-up timer lets the CPU clock run
  input wire logic [7:0] divide_factor, // Software divide setting
  input wire logic clk_out_en, // Clock output enable
  output logic cpu_tick, // One pulse per CPU clock cycle
  output logic periph_tick, // One pulse per peripheral clock cycle
  output logic machine_tick, // One pulse per machine cycle
  output logic clk_out // Square wave at half the CPU clock
);

  clk_pkg::div_state_t st;
  clk_pkg::div_state_t next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // The setting is taken only at a period boundary, so a write never cuts a period short
  always_comb
  begin
    logic [8:0] last;
    last = (st.cur_m == 8'h00) ? 9'h000 : ({st.cur_m, 1'b0} - 9'h001); // [RULE12]
    next_st = st;
    next_st.cpu_tick = 1'b0;
    next_st.periph_tick = 1'b0;
    next_st.machine_tick = 1'b0;
    if (!aresetn)
    begin
      next_st = '0;
      next_st.cur_m = `DIV_RESET;
    end
    else
    begin
      if (run && root_tick)
      begin
        if (st.cnt >= last)
        begin
          next_st.cnt = 9'h000;
          next_st.cur_m = divide_factor; // [RULE10]
          next_st.cpu_tick = 1'b1;
          next_st.phase = ~st.phase;
          next_st.periph_tick = st.phase; // [RULE2]
          next_st.machine_tick = st.phase; // [RULE1]
          next_st.clk_out = ~st.clk_out; // [RULE7]
        end
        else
        begin
          next_st.cnt = st.cnt + 9'h001;
        end
      end
      if (!clk_out_en)
      begin
        next_st.clk_out = 1'b0; // [RULE7]
      end
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  assign cpu_tick = st.cpu_tick;
  assign periph_tick = st.periph_tick;
  assign machine_tick = st.machine_tick;
  assign clk_out = st.clk_out;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  bypass_passes_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE12]
    run && root_tick && st.cur_m == 8'h00 |=> cpu_tick)
    else $error("Undivided root tick did not give a CPU tick");
  periph_every_second_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    periph_tick |-> cpu_tick && !st.phase)
    else $error("Peripheral tick not on every second CPU tick");
  divide_period_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
    run && root_tick && st.cur_m != 8'h00 && st.cnt < {st.cur_m, 1'b0} - 9'h001
    |=> !cpu_tick)
    else $error("CPU tick came before the divide period ended");
  clock_out_pin_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
    cpu_tick && $past(clk_out_en) |-> clk_out != $past(clk_out))
    else $error("Clock output did not toggle on a CPU tick");

endmodule // clock_divider

// *** verilog/wakeup_timer.sv ***
// Holds the CPU clock back after reset or wake-up until the oscillator settles
`include "clk_cfg.svh"

module wakeup_timer
#(
  parameter int ROOT_CYCLES = `WAKE_ROOT_CYCLES, // Root cycles to wait
  parameter int EXTRA_CYCLES = `WAKE_EXTRA_CYCLES // System cycles added afterwards
)
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic root_tick, // One pulse per root oscillator cycle
  input wire logic wake_req, // Pulse: leaving power-down, restart the wait
  output logic ready // CPU clock may run
);

  clk_pkg::wake_state_t st;
  clk_pkg::wake_state_t next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Root cycles first, then a fixed time, since a stopped oscillator gives no ticks
  always_comb
  begin
    next_st = st;
    if (!aresetn)
    begin
      next_st = '0;
      next_st.phase = clk_pkg::WAKE_ROOT;
    end
    else
    begin
      case (st.phase)
        clk_pkg::WAKE_ROOT:
        begin
          if (root_tick)
          begin
            if (st.root_cnt == 8'(ROOT_CYCLES - 1)) // [RULE11]
            begin
              next_st.phase = clk_pkg::WAKE_EXTRA;
              next_st.root_cnt = 8'h00;
            end
            else
            begin
              next_st.root_cnt = st.root_cnt + 8'h01;
            end
          end
        end
        clk_pkg::WAKE_EXTRA:
        begin
          if (st.extra_cnt == 16'(EXTRA_CYCLES - 1)) // [RULE11]
          begin
            next_st.phase = clk_pkg::WAKE_RUN;
            next_st.extra_cnt = 16'h0000;
            next_st.ready = 1'b1;
          end
          else
          begin
            next_st.extra_cnt = st.extra_cnt + 16'h0001;
          end
        end
        clk_pkg::WAKE_RUN:
        begin
          if (wake_req)
          begin
            next_st.phase = clk_pkg::WAKE_ROOT;
            next_st.ready = 1'b0;
          end
        end
        default:
        begin
          next_st.phase = clk_pkg::WAKE_ROOT;
          next_st.ready = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  assign ready = st.ready;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  root_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
    st.phase == clk_pkg::WAKE_ROOT ##1 st.phase == clk_pkg::WAKE_EXTRA
    |-> $past(st.root_cnt) == 8'(ROOT_CYCLES - 1) && $past(root_tick))
    else $error("Root wait ended at the wrong count");
  extra_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
    $rose(ready) |-> $past(st.extra_cnt) == 16'(EXTRA_CYCLES - 1))
    else $error("CPU clock released before the extra wait ended");

endmodule // wakeup_timer

// *** bench/ext_clock_source.sv ***
// External clock source that drives the block's clock input pin
module ext_clock_source
#(
  parameter int HALF_CYCLES = 3 // Half period in system cycles, 16.7 MHz
)
(
  input wire logic aclk, // System clock
  input wire logic run, // Source running
  output logic clk_pin // External clock pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic lvl = 1'b0;
  assign clk_pin = lvl;
  // Square wave kept under the 18 MHz ceiling; stands low while stopped
  always @(posedge aclk)
  begin
    if (!run)
    begin
      cnt <= 0;
      lvl <= 1'b0;
    end
    else if (cnt == HALF_CYCLES - 1)
    begin
      cnt <= 0;
      lvl <= ~lvl;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // ext_clock_source

// *** bench/tb_top.sv ***
// Self-checking bench for the clock source and divider block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, reset_pin_strap = 1'b1, wake_req = 1'b0;
  logic ext_run = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, external_clock_pin, awready, wready, bvalid, arready, rvalid;
  logic root_osc_clock, rc_osc_clock, cpu_core_clock, periph_clock, machine_cycle;
  logic clock_out_pin, cpu_clock_ready;
  logic [1:0] osc_select = 2'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [5:0] rc_trim_code;
  logic [7:0] seed = 8'h2f, m;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  int bad_count = 0, n_checks = 0, r, q;
  localparam logic [11:0] DIV = 12'h254, TRM = 12'h258, STS = 12'h25c, BAD = 12'hffc;

  // Short wake-up tail keeps the run brief
  clock_source_and_divider #(.WAKE_EXTRA_CYCLES(10)) clock_source_and_divider_inst (.aclk,
    .aresetn, .por_n, .osc_select, .reset_pin_strap, .external_clock_pin, .wake_req, .awaddr,
    .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .root_osc_clock, .rc_osc_clock, .rc_trim_code, .cpu_core_clock, .periph_clock,
    .machine_cycle, .clock_out_pin, .cpu_clock_ready);
  ext_clock_source ext_clock_source_inst (.aclk, .run(ext_run), .clk_pin(external_clock_pin));

  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tmo();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] e);
    int n = 0;
    wq.push_back(e);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50)
      tmo();
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n = 0;
    rq.push_back({e, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50)
      tmo();
    @(posedge aclk);
  endtask
  // Responses are compared against the oldest note as they appear
  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready)
      chk({32'h0, bresp}, {32'h0, wq.pop_front()}, "write response");
    if (rvalid === 1'b1 && rready)
      chk({rresp, rdata}, rq.pop_front(), "read data");
  end

  // ----------------------------------------------------------------------
  // Clock measurement tasks
  // ----------------------------------------------------------------------
  task automatic rst(input logic por);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n <= ~por;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic window();
    r = 0;
    q = 0;
    repeat (5000)
    begin
      @(posedge aclk);
      r += root_osc_clock;
      q += rc_osc_clock;
    end
  endtask
  // Root and CPU ticks seen while the CPU clock is held back
  task automatic hold();
    int n = 0;
    r = 0;
    q = 0;
    do
    begin
      @(posedge aclk);
      n++;
      r += root_osc_clock;
      // A tick launched at the wake edge itself is still legal
      if (n > 1)
        q += cpu_core_clock;
    end while (cpu_clock_ready !== 1'b1 && n < 5000);
    if (n >= 5000)
      tmo();
    chk(34'(q), 34'h0, "cpu ticks while held");
  endtask
  // Two ticks let a new divide setting land before four are measured
  task automatic measure(input int ratio, input logic en);
    int c = -2, rt = 0, p = 0, mc = 0, t = 0, n = 0;
    logic last = 1'b0;
    while (c < 4 && n < 40000)
    begin
      @(posedge aclk);
      n++;
      if (c >= 0)
      begin
        rt += root_osc_clock;
        p += periph_clock;
        mc += machine_cycle;
        t += (clock_out_pin !== last);
      end
      last = clock_out_pin;
      c += cpu_core_clock;
    end
    if (n >= 40000)
      tmo();
    chk(34'(rt), 34'(4 * ratio), "root ticks per four cpu ticks");
    chk(34'(p), 34'h2, "peripheral ticks");
    chk(34'(mc), 34'h2, "machine cycles");
    chk(34'(t), en ? 34'h4 : 34'h0, "clock out toggles");
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      osc_select <= (i == 2) ? 2'h3 : 2'(i);
      rst(1'b0);
      rd(STS, 8'h08 | 8'(i == 1), 2'h0);
      window();
      chk(34'(q >= 367 && q <= 370), 34'h1, "rc rate");
      chk(34'(i == 1 ? r >= 19 && r <= 21 : r >= 367 && r <= 370), 34'h1, "root");
    end
    rd(DIV, 8'h00, 2'h0);
    rd(TRM, 8'h20, 2'h0);
    wr(TRM, 8'h45, 4'hf, 2'h0);
    wr(TRM, 8'h00, 4'h0, 2'h0);
    rd(TRM, 8'h45, 2'h0);
    chk(34'(rc_trim_code), 34'h5, "trim code");
    window();
    chk(34'(q < 355 || q > 382), 34'h1, "rc retuned");
    wr(BAD, 8'h11, 4'hf, 2'h2);
    rd(BAD, 8'h00, 2'h2);
    osc_select <= 2'h2;
    ext_run <= 1'b1;
    rst(1'b0);
    hold();
    rd(STS, 8'h0e, 2'h0);
    rd(TRM, 8'h45, 2'h0);
    measure(1, 1'b1);
    seed = lfsr(seed);
    m = 8'(seed % 7) + 8'h1;
    wr(DIV, m, 4'hf, 2'h0);
    measure(2 * int'(m), 1'b1);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    hold();
    chk(34'(r >= 224 && r <= 227), 34'h1, "wake root ticks");
    wr(TRM, 8'h05, 4'hf, 2'h0);
    wr(DIV, 8'hff, 4'hf, 2'h0);
    measure(510, 1'b0);
    rst(1'b1);
    rd(TRM, 8'h20, 2'h0);
    rd(DIV, 8'h00, 2'h0);
    summarize();
  end
endmodule // tb_top
